// ==== pef_pkg.sv ====
`default_nettype none
package pef_pkg;
   // ****************************************
   // register indices and field layout
   // ****************************************
   localparam logic [13:0] IDX_CFG    = 14'h0400;
   localparam logic [13:0] IDX_STATUS = 14'h0402;
   localparam logic [13:0] IDX_TAP0   = 14'h0418;
   localparam logic [13:0] IDX_TAP1   = 14'h041a;
   localparam logic [13:0] IDX_TAP2   = 14'h041c;
   localparam int          SHARE_BIT  = 6;
   localparam int          MERGE_BIT  = 5;
   localparam int          SCW_LSB    = 2;
   localparam int          MODE_LSB   = 0;
   localparam logic [1:0]  MODE_OFF   = 2'h0;
   localparam logic [1:0]  MODE_ON    = 2'h2;
   localparam logic [2:0]  SCW_MAX    = 3'h6;
   localparam logic [7:0]  CFG_RESET  = 8'h00;
   localparam logic [7:0]  CFG_MASK   = 8'h7f;
   localparam logic [11:0] COEF_RESET = 12'h000;
   localparam int          COEF_W     = 12;
   localparam int          CENTER_W   = 18;
   localparam int          SAMPLE_W   = 12;
   localparam int          NTAPS      = 9;
   localparam int          CENTER_IDX = 4;
   localparam int          CENTER_FRAC = 17;
   localparam int          SIDE_FRAC  = 16;

   typedef logic signed [CENTER_W-1:0]       pef_coef_t;
   typedef logic [NTAPS-1:0][CENTER_W-1:0]   pef_taps_t;
   typedef logic [NTAPS-1:0][SAMPLE_W-1:0]   pef_win_t;
   typedef enum logic [1:0] {
      APB_IDLE = 2'b00,
      APB_WAIT = 2'b01,
      APB_DONE = 2'b11
   } pef_apb_st_t;

   function automatic logic [15:0] pefByteAddr(input logic [13:0] idx);
      pefByteAddr = {idx, 2'b00};
   endfunction

   function automatic logic [CENTER_W-1:0] pefSideExt(input logic [COEF_W-1:0] c);
      pefSideExt = {{(CENTER_W-COEF_W){c[COEF_W-1]}}, c};
   endfunction
endpackage
`default_nettype wire

// ==== pef_mac_if.sv ====
`default_nettype none
interface pef_mac_if;
   import pef_pkg::*;
   pef_win_t              window;
   pef_taps_t             taps;
   logic [2:0]            scw;
   logic                  enable;
   logic                  validIn;
   logic [SAMPLE_W-1:0]   result;
   logic                  validOut;
   modport src (output window, taps, scw, enable, validIn, input result, validOut);
   modport mac (input window, taps, scw, enable, validIn, output result, validOut);
endinterface
`default_nettype wire

// ==== pef_mac.sv ====
`default_nettype none
module pef_mac
   import pef_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst,
   pef_mac_if.mac    m
);
   // ****************************************
   // nine-tap multiply accumulate
   // ****************************************
   localparam int ACC_W = 40;
   logic signed [ACC_W-1:0] sideSum;
   logic signed [ACC_W-1:0] acc;
   logic signed [ACC_W-1:0] scaled;
   logic [SAMPLE_W-1:0]     satVal;

   always_comb begin
      sideSum = '0;
      for (int k = 0; k < NTAPS; k++) begin
         if (k != CENTER_IDX) begin
            sideSum = sideSum + ACC_W'($signed(m.taps[k]) * $signed(m.window[k]));
         end
      end
      // side lsb is 2^(scw-16), center lsb 2^-17: align both to 2^-17
      acc = (sideSum <<< (32'(m.scw) + 1)) + ACC_W'($signed(m.taps[CENTER_IDX])
            * $signed(m.window[CENTER_IDX])); // [RULE4] [RULE11]
      scaled = acc >>> CENTER_FRAC;
      if (scaled > ACC_W'(2047)) begin
         satVal = 12'h7ff;
      end else if (scaled < -ACC_W'(2048)) begin
         satVal = 12'h800;
      end else begin
         satVal = scaled[SAMPLE_W-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         m.result   <= '0;
         m.validOut <= 1'b0;
      end else begin
         m.validOut <= m.validIn;
         if (m.validIn) begin
            // bypass keeps the same one-cycle latency as the filtered path
            m.result <= m.enable ? satVal : m.window[0]; // [RULE12]
         end
      end
   end
endmodule
`default_nettype wire

// ==== pef_prog_fir.sv ====
// Contract
// RULE1: with the share bit set channel B filters with the channel A taps, else its own.
// RULE2: with the merge bit set both filters act as one filter over one interleaved sample stream.
// RULE3: software sets the merge bit whenever the converter runs single-channel.
// RULE4: the side weight field scales each non-center coef lsb to 2^(field-16), 0..6 valid.
// RULE5: mode 0 (reset) disables the filter, mode 2 enables it, codes 1 and 3 are reserved.
// RULE6: software that enables the filter also writes the coefficient registers.
// RULE7: software changes configuration and coefficients only while the serial link is disabled.
// RULE8: a side coefficient register holds a signed 12-bit value in bits 11:0, 15:12 reserved.
// RULE9: the three coefficient registers feed taps one to three of the channel A or merged filter.
// RULE10: coefficient readback shows 0 in its msb while the filter uses the written value.
// RULE11: the filter has nine taps; the fifth is the 18-bit center tap, not side-weighted.
// RULE12: with the filter disabled samples pass unchanged with equal latency on both channels.
// RULE13: reserved configuration and coefficient bits read as zero and do nothing.
//
// Register access over APB was decided locally.
`default_nettype none
module pef_prog_fir
   import pef_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [15:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  serialLinkEnable,
   input  wire logic [SAMPLE_W-1:0]   sampleA,
   input  wire logic [SAMPLE_W-1:0]   sampleB,
   input  wire logic                  sampleValid,
   input  wire logic [5:0][CENTER_W-1:0] tapsUpperA,
   input  wire pef_taps_t             tapsB,
   output logic      [SAMPLE_W-1:0]   outA,
   output logic      [SAMPLE_W-1:0]   outB,
   output logic                       outValid
);
   // ****************************************
   // register file
   // ****************************************
   logic [7:0]        filter_config_reg;
   logic [COEF_W-1:0] tap0_coefficient_reg;
   logic [COEF_W-1:0] tap1_coefficient_reg;
   logic [COEF_W-1:0] tap2_coefficient_reg;
   pef_apb_st_t       apbState_reg;
   pef_apb_st_t       apbState_next;
   logic              accessDone;
   logic              hitCfg;
   logic              hitStatus;
   logic              hitTap0;
   logic              hitTap1;
   logic              hitTap2;
   logic              hitAny;
   logic [31:0]       readData;
   logic              shareOn;
   logic              mergeOn;
   logic              filterOn;
   logic [2:0]        scwEff;
   pef_taps_t         tapsA;

   assign hitCfg     = paddr == pefByteAddr(IDX_CFG);
   assign hitStatus  = paddr == pefByteAddr(IDX_STATUS);
   assign hitTap0    = paddr == pefByteAddr(IDX_TAP0);
   assign hitTap1    = paddr == pefByteAddr(IDX_TAP1);
   assign hitTap2    = paddr == pefByteAddr(IDX_TAP2);
   assign hitAny     = hitCfg | hitStatus | hitTap0 | hitTap1 | hitTap2;
   assign accessDone = psel & penable & (apbState_reg == APB_DONE);

   // ****************************************
   // apb handshake: two wait states
   // ****************************************
   always_comb begin
      apbState_next = apbState_reg;
      unique case (apbState_reg)
         APB_IDLE: if (psel & penable) apbState_next = APB_WAIT;
         APB_WAIT: apbState_next = APB_DONE;
         APB_DONE: apbState_next = APB_IDLE;
         default:  apbState_next = APB_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         apbState_reg <= APB_IDLE;
      end else begin
         apbState_reg <= apbState_next;
      end
   end

   always_comb begin
      readData = '0;
      if (hitCfg) begin
         readData[7:0] = filter_config_reg & CFG_MASK; // [RULE13]
      end else if (hitStatus) begin
         readData[1:0] = {serialLinkEnable, filterOn};
      end else if (hitTap0) begin
         readData[COEF_W-2:0] = tap0_coefficient_reg[COEF_W-2:0]; // [RULE10] [RULE13]
      end else if (hitTap1) begin
         readData[COEF_W-2:0] = tap1_coefficient_reg[COEF_W-2:0]; // [RULE10]
      end else if (hitTap2) begin
         readData[COEF_W-2:0] = tap2_coefficient_reg[COEF_W-2:0]; // [RULE10]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= apbState_next == APB_DONE;
         pslverr <= (apbState_next == APB_DONE) & ~hitAny;
         if (apbState_next == APB_DONE && !pwrite) begin
            prdata <= readData;
         end
      end
   end

   // writes land at the completing edge; reserved bits are not stored
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         filter_config_reg    <= CFG_RESET; // [RULE5]
         tap0_coefficient_reg <= COEF_RESET;
         tap1_coefficient_reg <= COEF_RESET;
         tap2_coefficient_reg <= COEF_RESET;
      end else if (accessDone && pwrite) begin
         if (hitCfg) filter_config_reg <= pwdata[7:0] & CFG_MASK; // [RULE13]
         if (hitTap0) tap0_coefficient_reg <= pwdata[COEF_W-1:0]; // [RULE8]
         if (hitTap1) tap1_coefficient_reg <= pwdata[COEF_W-1:0]; // [RULE8]
         if (hitTap2) tap2_coefficient_reg <= pwdata[COEF_W-1:0]; // [RULE8]
      end
   end

   // ****************************************
   // configuration decode and coefficient sets
   // ****************************************
   assign shareOn  = filter_config_reg[SHARE_BIT];
   assign mergeOn  = filter_config_reg[MERGE_BIT];
   assign filterOn = filter_config_reg[MODE_LSB+:2] == MODE_ON; // [RULE5]
   // a reserved weight of 7 is held at the largest legal weight
   assign scwEff   = (filter_config_reg[SCW_LSB+:3] > SCW_MAX) ? SCW_MAX
                     : filter_config_reg[SCW_LSB+:3]; // [RULE4]

   always_comb begin
      tapsA    = '0;
      tapsA[0] = pefSideExt(tap0_coefficient_reg); // [RULE9]
      tapsA[1] = pefSideExt(tap1_coefficient_reg); // [RULE9]
      tapsA[2] = pefSideExt(tap2_coefficient_reg); // [RULE9]
      for (int k = 3; k < NTAPS; k++) begin
         tapsA[k] = (k == CENTER_IDX) ? tapsUpperA[k-3]
                    : pefSideExt(tapsUpperA[k-3][COEF_W-1:0]); // [RULE11]
      end
   end

   // ****************************************
   // sample history and filter windows
   // ****************************************
   logic [NTAPS-1:1][SAMPLE_W-1:0] histA_reg;
   logic [NTAPS-1:1][SAMPLE_W-1:0] histB_reg;
   logic [NTAPS-1:0][SAMPLE_W-1:0] allA;
   logic [NTAPS-1:0][SAMPLE_W-1:0] allB;

   assign allA = {histA_reg, sampleA};
   assign allB = {histB_reg, sampleB};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         histA_reg <= '0;
         histB_reg <= '0;
      end else if (sampleValid) begin
         histA_reg <= allA[NTAPS-2:0];
         histB_reg <= allB[NTAPS-2:0];
      end
   end

   pef_mac_if ifA ();
   pef_mac_if ifB ();

   // merged stream order, oldest first: ... A[n-1] B[n-1] A[n] B[n]
   always_comb begin
      for (int k = 0; k < NTAPS; k++) begin
         if (mergeOn) begin
            ifA.window[k] = k[0] ? allB[(k+1)/2] : allA[k/2]; // [RULE2]
            ifB.window[k] = k[0] ? allA[(k-1)/2] : allB[k/2]; // [RULE2]
         end else begin
            ifA.window[k] = allA[k];
            ifB.window[k] = allB[k];
         end
      end
   end

   assign ifA.taps    = tapsA;
   assign ifB.taps    = (shareOn | mergeOn) ? tapsA : tapsB; // [RULE1] [RULE2]
   assign ifA.scw     = scwEff;
   assign ifB.scw     = scwEff;
   assign ifA.enable  = filterOn;
   assign ifB.enable  = filterOn;
   assign ifA.validIn = sampleValid;
   assign ifB.validIn = sampleValid;

   pef_mac u_macA (.ref_clk(ref_clk), .rst(rst), .m(ifA));
   pef_mac u_macB (.ref_clk(ref_clk), .rst(rst), .m(ifB));

   assign outA     = ifA.result;
   assign outB     = ifB.result;
   assign outValid = ifA.validOut;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_share;
      shareOn |-> ifB.taps == ifA.taps;
   endproperty
   a_share: assert property (p_share) else $error("b taps differ from a under share"); // [RULE1]

   property p_merge;
      mergeOn |-> ifB.window[1] == sampleA && ifA.window[1] == histB_reg[1];
   endproperty
   a_merge: assert property (p_merge) else $error("merged window order wrong"); // [RULE2]

   property p_scw;
      scwEff <= SCW_MAX && (scwEff == filter_config_reg[4:2] || filter_config_reg[4:2] == 3'h7);
   endproperty
   a_scw: assert property (p_scw) else $error("side weight not applied"); // [RULE4]

   property p_mode;
      sampleValid && filter_config_reg[1:0] != MODE_ON |=> outValid && outA == $past(sampleA);
   endproperty
   a_mode: assert property (p_mode) else $error("disabled filter altered channel a"); // [RULE5]

   property p_tapwrite;
      accessDone && pwrite && hitTap0 ##1 !(accessDone && pwrite && hitTap0)
         |-> tap0_coefficient_reg == $past(pwdata[11:0]);
   endproperty
   a_tapwrite: assert property (p_tapwrite) else $error("coefficient not stored"); // [RULE8]

   property p_taps;
      $signed(ifA.taps[2]) == $signed(tap2_coefficient_reg)
         && ifA.taps[0][17:11] == {7{tap0_coefficient_reg[11]}};
   endproperty
   a_taps: assert property (p_taps) else $error("register taps not fed"); // [RULE9]

   property p_readback;
      pready && !pwrite && (hitTap0 || hitTap1 || hitTap2) |-> prdata[31:11] == '0;
   endproperty
   a_readback: assert property (p_readback) else $error("coef msb read nonzero"); // [RULE10]

   property p_center;
      ifA.taps[CENTER_IDX] == tapsUpperA[1];
   endproperty
   a_center: assert property (p_center) else $error("center tap lost resolution"); // [RULE11]

   property p_bypass;
      sampleValid && !filterOn |=> outB == $past(sampleB) && outA == $past(sampleA);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass latency differs"); // [RULE12]

   property p_reserved;
      pready && !pwrite && hitCfg |-> prdata[31:7] == '0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved cfg bits read set"); // [RULE13]

   property p_apb;
      psel && penable && !pready |-> ##[1:2] pready;
   endproperty
   a_apb: assert property (p_apb) else $error("apb answer late");
endmodule
`default_nettype wire

// ==== pef_adc_model.sv ====
`default_nettype none
module pef_adc_model
   import pef_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                fire,
   input  wire logic [SAMPLE_W-1:0] fireA,
   input  wire logic [SAMPLE_W-1:0] fireB,
   output logic      [SAMPLE_W-1:0] sampleA,
   output logic      [SAMPLE_W-1:0] sampleB,
   output logic                     sampleValid
);
   timeunit 1ns;
   timeprecision 1ps;
   // *****************************
   // sample pair source
   // *****************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sampleValid <= 1'b0;
         sampleA     <= '0;
         sampleB     <= '0;
      end else if (fire) begin
         // one a/b pair per valid cycle
         sampleValid <= 1'b1;
         sampleA     <= fireA;
         sampleB     <= fireB;
      end else begin
         // lines outside valid invert every cycle instead of holding the last sample
         sampleValid <= 1'b0;
         sampleA     <= ~sampleA;
         sampleB     <= ~sampleB;
      end
   end
endmodule
`default_nettype wire

// ==== pef_prog_fir_bench.sv ====
`default_nettype none
module pef_prog_fir_bench
   import pef_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                ref_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic                serialLinkEnable, sampleValid, outValid, fire;
   logic [15:0]         paddr;
   logic [31:0]         pwdata, prdata;
   logic [SAMPLE_W-1:0] sampleA, sampleB, outA, outB, fireA, fireB;
   int                  bad_count, n_tests;
   logic [13:0]         tapIdx [3] = '{IDX_TAP0, IDX_TAP1, IDX_TAP2};
   int                  scwSet [4] = '{0, 3, 6, 7};
   logic [5:0][CENTER_W-1:0] tapsUp;
   pef_taps_t           tapsBv;

   pef_prog_fir i_pef_prog_fir (
      .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serialLinkEnable(serialLinkEnable), .sampleA(sampleA), .sampleB(sampleB),
      .sampleValid(sampleValid), .tapsUpperA(tapsUp), .tapsB(tapsBv), .outA(outA), .outB(outB),
      .outValid(outValid));
   pef_adc_model i_pef_adc_model (
      .ref_clk(ref_clk), .rst(rst), .fire(fire), .fireA(fireA), .fireB(fireB),
      .sampleA(sampleA), .sampleB(sampleB), .sampleValid(sampleValid));

   // *****************************
   // helpers
   // *****************************
   task automatic close_out();
      $display("mismatches %0d of %0d comparisons", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // expected filter output for one nonzero side tap
   function automatic logic [11:0] fx(input logic signed [11:0] c, x, input int s);
      longint acc;
      acc = (longint'(c) * longint'(x)) <<< (s + 1);
      acc = acc >>> 17;
      if (acc > 2047) acc = 2047;
      if (acc < -2048) acc = -2048;
      fx = acc[11:0];
   endfunction

   task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
                      input logic [31:0] er, input logic ee);
      int n;
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (n = 0; n < 9; n++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 9) bad_count++;
      if (n == 9) close_out();
      if (!wr) chk(prdata, er);
      chk({31'h0, pslverr}, {31'h0, ee});
   endtask

   task automatic smp(input logic [11:0] a, b, ea, eb);
      int n;
      @(posedge ref_clk);
      fire  <= 1'b1;
      fireA <= a;
      fireB <= b;
      @(posedge ref_clk);
      fire <= 1'b0;
      for (n = 0; n < 8; n++) begin
         @(posedge ref_clk);
         #1;
         if (outValid === 1'b1) break;
      end
      if (n == 8) bad_count++;
      if (n == 8) close_out();
      chk(n, 0);
      chk({20'h0, outA}, {20'h0, ea});
      chk({20'h0, outB}, {20'h0, eb});
   endtask

   // *****************************
   // clock and sequence
   // *****************************
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      int k, j, s;
      logic [11:0] c, e, x, y;
      {rst, psel, penable, pwrite, serialLinkEnable, fire} = 6'b100000;
      {paddr, pwdata, fireA, fireB} = '0;
      tapsUp = '0;
      tapsBv = '0;
      bad_count = 0;
      n_tests = 0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      apb(0, IDX_CFG, 0, 32'h0, 0);
      for (k = 0; k < 3; k++) apb(0, tapIdx[k], 0, 32'h0, 0);
      apb(1, IDX_CFG, 32'hffff_ffff, 0, 0);
      apb(0, IDX_CFG, 0, 32'h7f, 0);
      apb(1, IDX_TAP0, 32'hffff_ffff, 0, 0);
      apb(0, IDX_TAP0, 0, 32'h7ff, 0);
      apb(1, 14'h0401, 32'h1, 0, 1);
      apb(0, 14'h0401, 0, 32'h0, 1);
      serialLinkEnable <= 1'b1;
      apb(0, IDX_STATUS, 0, 32'h2, 0);
      serialLinkEnable <= 1'b0;
      apb(1, IDX_TAP0, 0, 0, 0);
      for (k = 0; k < 4; k++) begin
         if (k == 2) continue;
         apb(1, IDX_CFG, k, 0, 0);
         smp(12'h123, 12'h9bc, 12'h123, 12'h9bc);
      end
      // one side tap at a time, shared set, weights 0, 3, 6 and reserved 7
      for (k = 0; k < 3; k++) begin
         c = (k == 1) ? 12'h800 : 12'h400;
         apb(1, tapIdx[k], {20'h0, c}, 0, 0);
         apb(0, tapIdx[k], 0, {21'h0, c[10:0]}, 0);
         for (s = 0; s < 4; s++) begin
            apb(1, IDX_CFG, {24'h0, 8'h40 | 8'(scwSet[s] << SCW_LSB) | 8'(MODE_ON)}, 0, 0);
            e = fx(c, 12'h100, (scwSet[s] > 6) ? 6 : scwSet[s]);
            for (j = 0; j < 3; j++) begin
               x = (j == 0) ? 12'h100 : 12'h0;
               y = (j == k) ? e : 12'h0;
               smp(x, x, y, y);
            end
         end
         apb(0, IDX_STATUS, 0, 32'h1, 0);
         apb(1, tapIdx[k], 0, 0, 0);
      end
      apb(1, IDX_TAP0, 32'h400, 0, 0);
      apb(1, IDX_CFG, {30'h0, MODE_ON}, 0, 0);
      smp(12'h100, 12'h100, fx(12'h400, 12'h100, 0), 12'h0);
      smp(12'h0, 12'h0, 12'h0, 12'h0);
      smp(12'h0, 12'h0, 12'h0, 12'h0);
      // merged stream: b feeds a's second tap one pair later
      apb(1, IDX_TAP0, 0, 0, 0);
      apb(1, IDX_TAP1, 32'h400, 0, 0);
      apb(1, IDX_CFG, {26'h0, 1'b1, 3'h0, MODE_ON}, 0, 0);
      e = fx(12'h400, 12'h100, 0);
      smp(12'h100, 12'h0, 12'h0, e);
      smp(12'h0, 12'h100, 12'h0, 12'h0);
      smp(12'h0, 12'h0, e, 12'h0);
      // center taps from the ports, full weight 6 must not scale them; b uses its own set
      apb(1, IDX_TAP1, 0, 0, 0);
      apb(1, IDX_CFG, {24'h0, 8'h18 | 8'(MODE_ON)}, 0, 0);
      for (j = 0; j < 9; j++) begin
         if (j == 4) begin
            @(posedge ref_clk);
            tapsUp[1]          <= 18'h10000;
            tapsBv[CENTER_IDX] <= 18'h08000;
         end
         x = (j == 4) ? 12'h100 : 12'h0;
         smp(x, x, (j == 8) ? 12'h080 : 12'h0, (j == 8) ? 12'h040 : 12'h0);
      end
      close_out();
   end
endmodule
`default_nettype wire
